// File: hdl/sac_pkg.sv
package sac_pkg;
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int FIELD_BITS = 8;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 8;
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 0;
  // channel addresses
  localparam logic [7:0] ADDR_CH1 = 8'h00;
  localparam logic [7:0] ADDR_CH2 = 8'h01;
  localparam logic [7:0] ADDR_CH3 = 8'h02;
  localparam int NUM_CH = 2;
  // attenuation code ranges
  localparam logic [7:0] CODE_FINE_LAST = 8'h5F;
  localparam logic [7:0] CODE_COARSE_FIRST = 8'h60;
  localparam logic [7:0] CODE_COARSE_LAST = 8'h7E;
  localparam logic [7:0] CODE_MUTE_FIRST = 8'h7F;
  // attenuation in half-dB units
  localparam logic [7:0] HALF_DB_COARSE_BASE = 8'h60;
  localparam logic [7:0] HALF_DB_MUTE = 8'hC8;
  // reset values and synchroniser depth
  localparam logic [7:0] RST_CODE = 8'hFF;
  localparam logic [15:0] RST_SHIFT = 16'h0000;
  localparam logic RST_MUTE = 1'b1;
  localparam logic RST_SCLK_LEVEL = 1'b0;
  localparam logic RST_LOAD_LEVEL = 1'b1;
  localparam int SYNC_STAGES = 2;
endpackage

// File: hdl/sac_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for one pin
module sac_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pin and synchronised level
  input wire logic pin,
  output logic level
);
  logic [1:0] stage_reg;
  logic [1:0] stage_next;

  // shift pin through both stages
  always_comb begin
    stage_next = {stage_reg[0], pin};
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage_reg <= 2'h0;
    end else begin
      stage_reg <= stage_next;
    end
  end

  assign level = stage_reg[1];
endmodule
`default_nettype wire

// File: hdl/sac_top.sv
`timescale 1ns/100ps
`default_nettype none
module sac_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // serial link pins
  input wire logic sclk,
  input wire logic load_shift,
  input wire logic data_in,
  output logic data_out,
  // channel one setting
  output logic [7:0] ch1_code,
  output logic [7:0] ch1_half_db,
  output logic ch1_mute,
  // channel two setting
  output logic [7:0] ch2_code,
  output logic [7:0] ch2_half_db,
  output logic ch2_mute,
  // last latched frame fields
  output logic [7:0] channel_select_byte,
  output logic [7:0] attenuation_code_byte
);
  // synchronised pins
  logic [2:0] pin_raw;
  logic [2:0] pin_s;
  logic sclk_s;
  logic load_s;
  logic din_s;
  // edge detector state
  logic sclk_d_reg;
  logic sclk_d_next;
  logic load_d_reg;
  logic load_d_next;
  logic sclk_rise;
  logic load_rise;
  // shift chain state and its fields
  logic [sac_pkg::FRAME_BITS-1:0] shift_reg;
  logic [sac_pkg::FRAME_BITS-1:0] shift_next;
  logic [sac_pkg::FIELD_BITS-1:0] frame_addr;
  logic [sac_pkg::FIELD_BITS-1:0] frame_code;
  // last latched frame bytes
  logic [7:0] sel_reg;
  logic [7:0] sel_next;
  logic [7:0] att_reg;
  logic [7:0] att_next;

  // map attenuation code to half-dB units
  function automatic logic [7:0] code_to_half_db(input logic [7:0] code);
    logic [7:0] r;
    r = sac_pkg::HALF_DB_MUTE;
    if (code <= sac_pkg::CODE_FINE_LAST) begin
      r = code;
    end else if (code <= sac_pkg::CODE_COARSE_LAST) begin
      r = 8'((code - sac_pkg::CODE_COARSE_FIRST) << 1) + sac_pkg::HALF_DB_COARSE_BASE;
    end
    return r;
  endfunction

  // mute decode of a code
  function automatic logic code_is_mute(input logic [7:0] code);
    return code >= sac_pkg::CODE_MUTE_FIRST;
  endfunction

  // does an address byte name the given channel
  function automatic logic addr_selects(input logic [7:0] addr, input int ch);
    logic [7:0] own;
    own = sac_pkg::ADDR_CH1;
    if (ch == 1) begin
      own = sac_pkg::ADDR_CH2;
    end
    // third-channel and other codes match nobody
    return addr == own;
  endfunction

  // enable goes in inverted, so a cleared stage reads as enable high
  assign pin_raw = {data_in, ~load_shift, sclk};

  // every pin passes two flops before logic reads it
  for (genvar p = 0; p < 3; p++) begin : g_sync
    sac_sync u_sync (
      .clock(clock),
      .rst(rst),
      .pin(pin_raw[p]),
      .level(pin_s[p])
    );
  end

  // synchronised levels, enable back to its pin sense
  assign sclk_s = pin_s[0];
  assign load_s = ~pin_s[1];
  assign din_s = pin_s[2];

  // rising edges of serial clock and enable
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign load_rise = load_s & ~load_d_reg;

  // edge detector next state
  always_comb begin
    sclk_d_next = sclk_s;
    load_d_next = load_s;
  end

  // detectors reset to the idle levels, so reset never fakes a latch
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_d_reg <= sac_pkg::RST_SCLK_LEVEL;
      load_d_reg <= sac_pkg::RST_LOAD_LEVEL;
    end else begin
      sclk_d_reg <= sclk_d_next;
      load_d_reg <= load_d_next;
    end
  end

  // one bit in per clock rise, only while enable is low
  always_comb begin
    shift_next = shift_reg;
    if (sclk_rise && !load_s) begin
      shift_next = {shift_reg[sac_pkg::FRAME_BITS-2:0], din_s};
    end
  end

  // shift chain register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_reg <= sac_pkg::RST_SHIFT;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // frame fields, address byte shifted in first
  assign frame_addr = shift_reg[sac_pkg::ADDR_MSB:sac_pkg::ADDR_LSB];
  assign frame_code = shift_reg[sac_pkg::CODE_MSB:sac_pkg::CODE_LSB];

  // both bytes latch on enable rise, whatever the address
  always_comb begin
    sel_next = sel_reg;
    att_next = att_reg;
    if (load_rise) begin
      sel_next = frame_addr;
      att_next = frame_code;
    end
  end

  // latched frame byte registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_reg <= sac_pkg::RST_CODE;
      att_reg <= sac_pkg::RST_CODE;
    end else begin
      sel_reg <= sel_next;
      att_reg <= att_next;
    end
  end

  // one settings set per channel
  for (genvar ch = 0; ch < sac_pkg::NUM_CH; ch++) begin : g_chan
    logic [7:0] code_reg;
    logic [7:0] code_next;
    logic [7:0] half_db_reg;
    logic [7:0] half_db_next;
    logic mute_reg;
    logic mute_next;
    logic hit;

    // only a latched frame naming this channel touches it
    assign hit = load_rise && addr_selects(frame_addr, ch);

    // new setting taken from the latched code
    always_comb begin
      code_next = code_reg;
      half_db_next = half_db_reg;
      mute_next = mute_reg;
      if (hit) begin
        code_next = frame_code;
        half_db_next = code_to_half_db(frame_code);
        mute_next = code_is_mute(frame_code);
      end
    end

    // every channel starts muted
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        code_reg <= sac_pkg::RST_CODE;
        half_db_reg <= sac_pkg::HALF_DB_MUTE;
        mute_reg <= sac_pkg::RST_MUTE;
      end else begin
        code_reg <= code_next;
        half_db_reg <= half_db_next;
        mute_reg <= mute_next;
      end
    end

    // route this channel to its port group
    if (ch == 0) begin : g_first
      assign ch1_code = code_reg;
      assign ch1_half_db = half_db_reg;
      assign ch1_mute = mute_reg;
    end else begin : g_second
      assign ch2_code = code_reg;
      assign ch2_half_db = half_db_reg;
      assign ch2_mute = mute_reg;
    end
  end

  // chain output is the oldest bit of the shift chain
  assign data_out = shift_reg[sac_pkg::FRAME_BITS-1];
  // latched bytes straight from their registers
  assign channel_select_byte = sel_reg;
  assign attenuation_code_byte = att_reg;
endmodule
`default_nettype wire

// File: dv/sac_host.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the three-wire link
module sac_host (
  // link pins
  output logic sclk,
  output logic load_shift,
  output logic data_in
);
  // link idles with clock still and enable low
  initial begin
    sclk = 1'b0;
    load_shift = 1'b0;
    data_in = 1'b0;
  end
  // shift one frame msb first, then set the enable
  task automatic send(input logic [15:0] f, input logic lo, input logic hi);
    load_shift = lo;
    #160;
    for (int i = 15; i >= 0; i--) begin
      data_in = f[i];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #160 load_shift = hi;
  endtask
endmodule
`default_nettype wire

// File: dv/sac_checker.sv
`timescale 1ns/100ps
`default_nettype none
module sac_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link pins
  input wire logic sclk,
  input wire logic load_shift,
  input wire logic data_in,
  input wire logic data_out,
  // channel settings
  input wire logic [7:0] ch1_code,
  input wire logic [7:0] ch1_half_db,
  input wire logic ch1_mute,
  input wire logic [7:0] ch2_code,
  input wire logic [7:0] ch2_half_db,
  input wire logic ch2_mute,
  // latched frame bytes
  input wire logic [7:0] channel_select_byte,
  input wire logic [7:0] attenuation_code_byte
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_mute_decode: assert property (ch1_mute == (ch1_code >= 8'h7F))
    else $error("mute flag wrong");
  a_mute_level: assert property (ch2_mute |-> ch2_half_db == 8'hC8)
    else $error("mute level wrong");
  a_reset_muted: assert property ($fell(rst) |-> ch1_mute && ch2_mute && ch1_code == 8'hFF)
    else $error("channel not muted after reset");
  a_fine_scale: assert property (ch1_code <= 8'h5F |-> ch1_half_db == ch1_code)
    else $error("fine step wrong");
  a_coarse_scale: assert property (ch1_code inside {[8'h60:8'h7E]}
    |-> ch1_half_db == 2 * ch1_code - 8'h60) else $error("coarse step wrong");
  a_hold_unloaded: assert property (!load_shift [*8] |=> $stable(ch1_code)
    && $stable(ch2_code) && $stable(channel_select_byte)) else $error("update without load");
  a_shift_gated: assert property (load_shift [*8] |=> $stable(data_out))
    else $error("shift while enable high");
  a_sclk_edge: assert property (!sclk [*8] |=> $stable(data_out))
    else $error("shift without clock rise");
  a_foreign_addr: assert property ($changed(channel_select_byte)
    && channel_select_byte > 8'h01 |-> $stable(ch1_code) && $stable(ch2_code))
    else $error("unknown address changed a channel");
  a_ch_select: assert property ($changed(attenuation_code_byte)
    && channel_select_byte == 8'h00 |-> ch1_code == attenuation_code_byte
    && $stable(ch2_code)) else $error("channel one not updated alone");
endmodule
bind sac_top sac_checker u_chk (.*);
`default_nettype wire

// File: dv/sac_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module sac_top_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sclk, load_shift, data_in, data_out, ch1_mute, ch2_mute;
  logic [7:0] ch1_code, ch1_half_db, ch2_code, ch2_half_db;
  logic [7:0] channel_select_byte, attenuation_code_byte;
  int failures = 0;
  int n_compared = 0;
  // frame, ch1 code, ch2 code, ch1 half dB, ch2 half dB
  logic [47:0] rows [7] = '{48'h0000_00FF_00C8, 48'h015F_005F_005F, 48'h0060_605F_605F,
    48'h017E_607E_609C, 48'h0261_607E_609C, 48'h007F_7F7E_C89C, 48'h0180_7F80_C8C8};
  sac_top DUT (.*);
  sac_host host (.*);
  // compare and count
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // send and latch a frame, bounded wait for the latch bytes
  task automatic load(input logic [15:0] f);
    int i;
    @(posedge clock) #1;
    host.send(f, 1'b0, 1'b1);
    for (i = 0; i < 20 && {channel_select_byte, attenuation_code_byte} !== f; i++) begin
      @(posedge clock) #1;
    end
    if (i == 20) begin
      failures++;
      results;
    end
    @(posedge clock) #1;
  endtask
  initial forever #2.5 clock = ~clock;
  initial begin
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    repeat (8) @(posedge clock);
    #1 check({ch1_code, ch2_code, ch1_half_db, ch2_half_db}, 32'hFFFF_C8C8);
    check({ch1_mute, ch2_mute, data_out, channel_select_byte}, 11'h6FF);
    foreach (rows[r]) begin
      load(rows[r][47:32]);
      check({ch1_code, ch2_code, ch1_half_db, ch2_half_db}, rows[r][31:0]);
      check({ch1_mute, ch2_mute}, {rows[r][31:24] >= 8'h7F, rows[r][23:16] >= 8'h7F});
    end
    // frame sent with enable left low, latched by the enable rise of the next send, then clock edges with enable high
    host.send(16'h8001, 1'b0, 1'b0);
    repeat (8) @(posedge clock);
    #1 check(data_out, 1'b1);
    host.send(16'h0000, 1'b1, 1'b0);
    repeat (8) @(posedge clock);
    #1 check(data_out, 1'b1);
    check({channel_select_byte, ch1_code}, 16'h807F);
    load(16'h0005);
    check({ch1_code, ch2_code}, 16'h0580);
    // reset in mid-run with the enable left high must not latch anything
    rst = 1'b1;
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    repeat (8) @(posedge clock);
    #1 check({ch1_code, ch2_code, ch1_half_db, ch2_half_db}, 32'hFFFF_C8C8);
    check({ch1_mute, ch2_mute, data_out, channel_select_byte}, 11'h6FF);
    load(16'h0120);
    check({ch1_mute, ch2_mute, ch1_code, ch2_code, ch2_half_db}, 26'h2FF_2020);
    results;
  end
endmodule
`default_nettype wire
